// ### verilog/back_emf_zc_pkg.sv
// package: constants and carrier types for the back-emf zero-crossing chain
package back_emf_zc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned EVAL_CYCLES = 25;
  localparam int unsigned NUM_TIMING_SETS = 4;
  localparam logic [11:0] UPPER_THRESHOLD_RST = 12'h7FF;
  localparam logic [11:0] LOWER_THRESHOLD_RST = 12'h000;
  localparam logic [7:0] PRECHARGE_RST = 8'h03;
  localparam logic [7:0] SAMPLE_CYCLES_RST = 8'h08;
  localparam logic [1:0] TIMING_SET_ZERO = 2'h0;
  localparam int unsigned CONV_DIV = 4;
  localparam int unsigned PWM_PERIOD_NS = 50000;
  localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned ROUTE_W = 53;
  localparam logic [23:0] ROUTE_ADDR_PH0 = 24'h000009;
  localparam logic [23:0] ROUTE_ADDR_PH1 = 24'h00000A;
  localparam logic [23:0] ROUTE_ADDR_PH2 = 24'h00000B;
  localparam int unsigned SHADOW_LOW_LSB = 0;
  localparam int unsigned SHADOW_HIGH_LSB = 24;
  localparam int unsigned CTRL_BITS_LSB = 48;
  localparam logic [1:0] RESULT_SEL_SHADOW_CNT = 2'h3;

  typedef struct packed {
    logic [7:0] precharge;
    logic [7:0] sample_cycles;
  } timing_set_t;

  typedef struct packed {
    logic [23:0] duty_result;
    logic [23:0] period_result;
    logic [7:0] edge_tally;
  } measure_t;

  typedef struct packed {
    logic [4:0] ctrl_bits;
    logic [23:0] shadow_high;
    logic [23:0] shadow_low;
  } route_word_t;
endpackage

// ### verilog/back_emf_zero_cross_detect.sv
// three-phase back-emf zero-crossing detector: converter, watchdog, capture, routed output
`timescale 1ns/10ps
module back_emf_zero_cross_detect
  import back_emf_zc_pkg::*;
#(
  parameter int unsigned PHASES = 3,
  parameter int unsigned PWM_CYC = PWM_PERIOD_CYC
)(
  input wire logic mclk, // 40 MHz capture clock
  input wire logic rst_b, // async reset, active low
  input wire logic converter_power_down, // 1 holds converters idle
  input wire logic inject_hw_trigger_on, // enables hardware conversion start
  input wire logic result_overwrite_on, // new result replaces unread one
  input wire logic start_request, // global start of trigger pwm only; outputs follow routing_on
  input wire logic routing_on, // forward filtered level to output channels
  input wire logic [1:0] timing_set_select [PHASES], // per-channel timing set
  input wire back_emf_zc_pkg::timing_set_t timing_sets [NUM_TIMING_SETS], // timing sets
  input wire logic [11:0] upper_threshold, // watchdog high threshold
  input wire logic [11:0] lower_threshold, // watchdog low threshold
  input wire logic [11:0] phase_sample [PHASES], // analog front-end result per phase
  input wire logic result_read [PHASES], // software consumed result
  output logic conversion_trigger_pwm, // trigger pwm, 50 percent
  output logic [11:0] conv_result [PHASES], // latest conversion result
  output logic conv_done [PHASES], // end-of-conversion request pulse
  output logic watchdog_pulse [PHASES], // one-cycle crossover pulse
  output logic filtered_level [PHASES], // deglitched capture level
  output back_emf_zc_pkg::measure_t measure [PHASES], // duty, period, edge tally
  output back_emf_zc_pkg::route_word_t routed_word [PHASES], // output channel shadows
  output logic hall_level [PHASES] // hall-like output pin
);
  import back_emf_zc_pkg::*;

  localparam int unsigned CW = $clog2(PWM_CYC + 1);
  localparam logic [CW-1:0] PER_MAX = CW'(PWM_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(PWM_CYC / 2);
  localparam logic [CW-1:0] FALL_FILT = CW'(PWM_CYC - 2);
  localparam logic [1:0] DIV_MAX = 2'(CONV_DIV - 1);

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_DONE = 2'b11
  } conv_state_t;

  function automatic logic [9:0] conv_len(input timing_set_t ts);
    conv_len = 10'(ts.precharge) + 10'(ts.sample_cycles) + 10'(EVAL_CYCLES);
  endfunction

  // crossover test: above the upper threshold, not below the lower one
  function automatic logic over_window(input logic [11:0] smp, input logic [11:0] lo,
    input logic [11:0] hi);
    over_window = (smp >= lo) && (smp > hi);
  endfunction

  function automatic logic rose_now(input logic cur, input logic prev);
    rose_now = cur && !prev;
  endfunction

  function automatic logic fell_now(input logic cur, input logic prev);
    fell_now = !cur && prev;
  endfunction

  // start/power synchronisers: these come from software timing, not this clock
  logic start_s1_q;
  logic start_s2_q;
  logic pd_s1_q;
  logic pd_s2_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_s1_q <= 1'b0;
      start_s2_q <= 1'b0;
      pd_s1_q <= 1'b1;
      pd_s2_q <= 1'b1;
    end
    else
    begin
      start_s1_q <= start_request;
      start_s2_q <= start_s1_q;
      pd_s1_q <= converter_power_down;
      pd_s2_q <= pd_s1_q;
    end
  end

  // trigger pwm: started by global request, high first half
  logic running_q;
  logic [CW-1:0] pwm_cnt_q;
  logic trig_prev_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      running_q <= 1'b0;
      pwm_cnt_q <= '0;
      conversion_trigger_pwm <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      if (start_s2_q)
        running_q <= 1'b1;
      if (running_q)
        pwm_cnt_q <= (pwm_cnt_q == PER_MAX) ? '0 : pwm_cnt_q + 1'b1;
      conversion_trigger_pwm <= running_q && (pwm_cnt_q < HALF);
      trig_prev_q <= conversion_trigger_pwm;
    end
  end

  // falling edge at mid-period samples during the on-time
  logic trig_fall;
  assign trig_fall = fell_now(conversion_trigger_pwm, trig_prev_q);

  // converter runs on every fourth edge, i.e. 10 MHz locked to mclk
  logic [1:0] div_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      div_q <= '0;
    else
      div_q <= (div_q == DIV_MAX) ? 2'h0 : div_q + 2'h1;
  end

  genvar g;
  generate
    for (g = 0; g < PHASES; g++)
    begin : g_phase
      conv_state_t st_q;
      logic [9:0] cc_q;
      logic pend_q;
      logic unread_q;
      logic conv_start;
      logic accept;
      logic [11:0] samp_s1_q;
      logic [11:0] samp_s2_q;
      timing_set_t ts;
      assign ts = timing_sets[timing_set_select[g]];
      assign conv_start = (st_q == CONV_IDLE) && pend_q && (div_q == 2'h0);
      assign accept = (st_q == CONV_DONE) && (result_overwrite_on || !unread_q);

      // the divided phase level is quasi-static across a conversion; a level that
      // moves while it is captured costs at most one stale result, never a hang
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          samp_s1_q <= '0;
          samp_s2_q <= '0;
        end
        else
        begin
          samp_s1_q <= phase_sample[g];
          samp_s2_q <= samp_s1_q;
        end
      end

      // a new trigger wins over the start that consumes the previous one
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          pend_q <= 1'b0;
        else if (trig_fall && inject_hw_trigger_on && !pd_s2_q)
          pend_q <= 1'b1;
        else if (conv_start)
          pend_q <= 1'b0;
      end

      // set wins over read: a fresh result is always reported unread
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          unread_q <= 1'b0;
        else if (accept)
          unread_q <= 1'b1;
        else if (result_read[g])
          unread_q <= 1'b0;
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          st_q <= CONV_IDLE;
          cc_q <= '0;
          conv_result[g] <= '0;
          conv_done[g] <= 1'b0;
          watchdog_pulse[g] <= 1'b0;
        end
        else
        begin
          conv_done[g] <= 1'b0;
          watchdog_pulse[g] <= 1'b0;
          case (st_q)
            CONV_IDLE:
            begin
              if (conv_start)
              begin
                cc_q <= conv_len(ts) - 10'h1;
                st_q <= CONV_RUN;
              end
            end
            CONV_RUN:
            begin
              if (pd_s2_q)
                st_q <= CONV_IDLE;
              else if (div_q == DIV_MAX)
              begin
                if (cc_q == '0)
                  st_q <= CONV_DONE;
                else
                  cc_q <= cc_q - 10'h1;
              end
            end
            CONV_DONE:
            begin
              st_q <= CONV_IDLE;
              if (accept)
              begin
                conv_result[g] <= samp_s2_q;
                conv_done[g] <= 1'b1;
                // pulse each result above the upper threshold and not below the lower one; one cycle each
                watchdog_pulse[g] <= over_window(samp_s2_q, lower_threshold,
                  upper_threshold);
              end
            end
            default: st_q <= CONV_IDLE;
          endcase
        end
      end

      // input filter: rise immediate, fall after N-1 clocks without a pulse
      logic [CW-1:0] flt_q;
      logic [CW-1:0] cnt_q;
      logic [CW-1:0] shadow_q;
      logic [7:0] tally_q;
      logic lvl_prev_q;
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          filtered_level[g] <= 1'b0;
          flt_q <= '0;
        end
        else if (watchdog_pulse[g])
        begin
          filtered_level[g] <= 1'b1;
          flt_q <= '0;
        end
        else if (filtered_level[g])
        begin
          if (flt_q == FALL_FILT)
          begin
            filtered_level[g] <= 1'b0;
            flt_q <= '0;
          end
          else
            flt_q <= flt_q + 1'b1;
        end
      end

      // pwm measurement, polarity high: duty from rise to fall
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          lvl_prev_q <= 1'b0;
          cnt_q <= '0;
          shadow_q <= '0;
          tally_q <= '0;
          measure[g] <= '0;
        end
        else
        begin
          lvl_prev_q <= filtered_level[g];
          if (rose_now(filtered_level[g], lvl_prev_q))
          begin
            measure[g].duty_result <= 24'(shadow_q);
            measure[g].period_result <= 24'(cnt_q);
            measure[g].edge_tally <= tally_q + 8'h1;
            tally_q <= tally_q + 8'h1;
            cnt_q <= CW'(1);
          end
          else
          begin
            if (fell_now(filtered_level[g], lvl_prev_q))
              shadow_q <= cnt_q;
            cnt_q <= cnt_q + 1'b1;
          end
        end
      end

      // routed output channel: word split and immediate output
      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          routed_word[g] <= '0;
          hall_level[g] <= 1'b0;
        end
        else if (routing_on)
        begin
          routed_word[g].shadow_low <= measure[g].duty_result;
          routed_word[g].shadow_high <= measure[g].period_result;
          routed_word[g].ctrl_bits <= {4'h0, filtered_level[g]};
          // one-cycle routing interval cannot see single-clock gaps
          if (filtered_level[g] || lvl_prev_q)
            hall_level[g] <= 1'b1;
          else
            hall_level[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

// ### dv/back_emf_zc_checker.sv
// checker: timing relations on phase 0 of the zero-crossing chain
`timescale 1ns/10ps
module back_emf_zc_checker
  import back_emf_zc_pkg::*;
#(
  parameter int unsigned PHASES = 3,
  parameter int unsigned PWM_CYC = PWM_PERIOD_CYC
)(
  input wire logic mclk, // clock
  input wire logic rst_b, // reset, active low
  input wire logic converter_power_down, // converter idle
  input wire logic inject_hw_trigger_on, // hardware start enable
  input wire logic routing_on, // routing enable
  input wire logic [1:0] timing_set_select [PHASES], // timing set per phase
  input wire logic conversion_trigger_pwm, // trigger pwm
  input wire logic conv_done [PHASES], // end of conversion
  input wire logic watchdog_pulse [PHASES], // crossover pulse
  input wire logic filtered_level [PHASES], // filtered level
  input wire logic hall_level [PHASES] // hall-like level
);
  localparam int HALF = PWM_CYC / 2;
  logic [15:0] high_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // run length of the filtered high time, judged when it drops
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      high_q <= 16'h0000;
    else if (filtered_level[0])
      high_q <= high_q + 16'h0001;
    else
      high_q <= 16'h0000;
  end
  sequence gap_s;
    $fell(filtered_level[0]) ##1 $rose(filtered_level[0]);
  endsequence
  pulse_one_cyc_a: assert property (watchdog_pulse[0] |=> !watchdog_pulse[0])
    else $error("watchdog pulse longer than one cycle");
  done_one_cyc_a: assert property (conv_done[0] |=> !conv_done[0])
    else $error("conversion done longer than one cycle");
  rise_pass_a: assert property (watchdog_pulse[0] |=> filtered_level[0])
    else $error("filtered level late after pulse");
  fall_time_a: assert property ($fell(filtered_level[0]) |-> high_q == 16'(PWM_CYC - 1))
    else $error("filtered high time wrong");
  trig_half_a: assert property (
    $rose(conversion_trigger_pwm) |-> ##[HALF:HALF] $fell(conversion_trigger_pwm))
    else $error("trigger high time not half period");
  conv_time_a: assert property ($fell(conversion_trigger_pwm) && inject_hw_trigger_on
    && !converter_power_down && timing_set_select[0] == 2'h0 |-> ##[140:152] conv_done[0])
    else $error("conversion length wrong");
  hall_rise_a: assert property ($rose(filtered_level[0]) && routing_on |=> hall_level[0])
    else $error("hall level did not follow");
  gap_bridge_a: assert property (routing_on throughout gap_s |-> hall_level[0])
    else $error("hall level showed a one-cycle gap");
  hall_low_a: assert property ((!filtered_level[0] && routing_on) [*3] |-> !hall_level[0])
    else $error("hall level high while filtered low");
endmodule

// ### dv/back_emf_phase_model.sv
// phase model: divided phase voltages and the side that reads results
`timescale 1ns/10ps
module back_emf_phase_model #(
  parameter int unsigned PHASES = 3
)(
  input wire logic mclk, // clock
  input wire logic [PHASES-1:0] above, // phase above half bus voltage
  input wire logic conv_done [PHASES], // end of conversion
  output logic [11:0] phase_sample [PHASES], // divided phase level
  output logic result_read [PHASES] // reader strobe
);
  initial
  begin
    phase_sample = '{default: 12'h400};
    result_read = '{default: 1'b0};
  end
  always @(posedge mclk)
  begin
    for (int i = 0; i < PHASES; i++)
    begin
      // levels sit well off mid-scale so a single sample decides the side
      phase_sample[i] <= above[i] ? 12'hC00 : 12'h400;
      // results are consumed at once, so no unread result is ever refused
      result_read[i] <= conv_done[i];
    end
  end
endmodule

// ### dv/back_emf_zero_cross_detect_tb.sv
// testbench: zero-crossing chain driven by the phase model
`timescale 1ns/10ps
module back_emf_zero_cross_detect_tb;
  import back_emf_zc_pkg::*;
  localparam int unsigned PH = 3;
  localparam int unsigned N = 400;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic pwr_dn = 1'b1;
  logic start_req = 1'b0;
  logic [11:0] upper = UPPER_THRESHOLD_RST;
  logic [2:0] above = 3'h0;
  logic [1:0] tsel [PH] = '{default: TIMING_SET_ZERO};
  timing_set_t tsets [NUM_TIMING_SETS] =
    '{default: timing_set_t'{PRECHARGE_RST, SAMPLE_CYCLES_RST}};
  logic trig;
  logic [11:0] conv_res [PH];
  logic done [PH];
  logic pulse [PH];
  logic filt [PH];
  measure_t meas [PH];
  route_word_t rw [PH];
  logic hall [PH];
  logic [11:0] sample [PH];
  logic rd [PH];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int n_done = 0;
  back_emf_zero_cross_detect #(.PHASES(PH), .PWM_CYC(N)) i_back_emf_zero_cross_detect (
    .mclk(mclk), .rst_b(rst_b), .converter_power_down(pwr_dn), .inject_hw_trigger_on(1'b1),
    .result_overwrite_on(1'b1), .start_request(start_req), .routing_on(1'b1),
    .timing_set_select(tsel), .timing_sets(tsets), .upper_threshold(upper),
    .lower_threshold(LOWER_THRESHOLD_RST), .phase_sample(sample), .result_read(rd),
    .conversion_trigger_pwm(trig), .conv_result(conv_res), .conv_done(done),
    .watchdog_pulse(pulse), .filtered_level(filt), .measure(meas), .routed_word(rw),
    .hall_level(hall));
  back_emf_phase_model #(.PHASES(PH)) i_back_emf_phase_model (
    .mclk(mclk), .above(above), .conv_done(done), .phase_sample(sample), .result_read(rd));
  always #12.5 mclk = ~mclk;
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // the ceiling allows more than twice the planned run
  always @(posedge mclk)
  begin
    cyc++;
    if (done[0] === 1'b1)
      n_done++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic t_powerdown();
    n_done = 0;
    repeat (3 * N) @(negedge mclk);
    check(24'(n_done), 24'h0, "conversion while powered down");
    pwr_dn = 1'b0;
    repeat (3 * N) @(negedge mclk);
    check(24'(n_done >= 2), 24'h1, "no conversion per period");
    $display("test powerdown done");
  endtask
  task automatic t_cross();
    int lows;
    logic [7:0] tally;
    lows = 0;
    above = 3'b101;
    repeat (5 * N) @(negedge mclk);
    check(conv_res[0], 12'hC00, "result not latest sample");
    check(meas[0].duty_result, 24'(N - 1), "duty length");
    check(meas[0].period_result, 24'(N), "period length");
    // the filtered level has a one-cycle gap per period: look past it
    while (filt[0] !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    check(rw[0].ctrl_bits[0], 1'b1, "routed level bit");
    check(rw[0].shadow_high, 24'(N), "routed period word");
    check(rw[0].shadow_low, 24'(N - 1), "routed duty word");
    tally = meas[0].edge_tally;
    check(filt[1], 1'b0, "filtered level on quiet phase");
    check(hall[1], 1'b0, "hall on phase below");
    check(hall[2], 1'b1, "hall on third phase");
    repeat (N)
    begin
      @(negedge mclk);
      if (hall[0] !== 1'b1)
        lows++;
    end
    check(24'(lows), 24'h0, "hall dropped inside a period");
    check(24'(8'(meas[0].edge_tally - tally)), 24'h1, "one measurement per period");
    $display("test crossing done");
  endtask
  task automatic t_thresh();
    upper = 12'hC00;
    repeat (3 * N) @(negedge mclk);
    check(hall[0], 1'b0, "pulse at a sample equal to threshold");
    upper = UPPER_THRESHOLD_RST;
    repeat (3 * N) @(negedge mclk);
    check(hall[0], 1'b1, "no pulse above threshold");
    $display("test threshold done");
  endtask
  task automatic t_fall();
    above = 3'b000;
    repeat (3 * N) @(negedge mclk);
    check(hall[0], 1'b0, "hall high below half bus");
    check(hall[2], 1'b0, "hall high below half bus");
    $display("test fall done");
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    start_req = 1'b1;
    t_powerdown();
    t_cross();
    t_thresh();
    t_fall();
    print_verdict();
  end
endmodule
bind back_emf_zero_cross_detect back_emf_zc_checker #(.PHASES(PHASES), .PWM_CYC(PWM_CYC)) i_back_emf_zc_checker (
  .mclk(mclk), .rst_b(rst_b), .converter_power_down(converter_power_down),
  .inject_hw_trigger_on(inject_hw_trigger_on), .routing_on(routing_on),
  .timing_set_select(timing_set_select), .conversion_trigger_pwm(conversion_trigger_pwm),
  .conv_done(conv_done), .watchdog_pulse(watchdog_pulse), .filtered_level(filtered_level),
  .hall_level(hall_level));
